//--- verilog/csc_pkg.sv
// constants for the clock source control block
`default_nettype none
package csc_pkg;
  // reset values of control state
  localparam logic       MAIN_STOP_RST     = 1'b1;
  localparam logic       SUB_EN_RST        = 1'b0;
  localparam logic       MAIN_SUB_RST      = 1'b0;
  localparam logic       PIN_FUNC_RST      = 1'b0;
  localparam logic       SRC_SEL_RST       = 1'b1;
  localparam logic       OSC_SEL_RST       = 1'b0;
  localparam logic       HS_EN_RST         = 1'b0;
  localparam logic       DIV8_RST          = 1'b1;
  localparam logic [1:0] CPU_DIV_RST       = 2'h0;
  localparam logic [1:0] DETECT_CFG_RST    = 2'h0;
  localparam logic [1:0] DETECT_AUTO       = 2'h3;
  localparam logic [2:0] HS_DIV_RST        = 3'h0;
  localparam int         TRIM_W            = 8;
  localparam logic [7:0] TRIM_RST          = 8'h80;
  localparam logic [7:0] TRIM_LOW_DEFAULT  = 8'h7C;
  localparam logic [7:0] TRIM_UART_DEFAULT = 8'h90;
  // trim copy commands
  localparam logic [1:0] TRIM_CMD_NONE     = 2'h0;
  localparam logic [1:0] TRIM_CMD_MID      = 2'h1;
  localparam logic [1:0] TRIM_CMD_LOW      = 2'h2;
  localparam logic [1:0] TRIM_CMD_UART     = 2'h3;
  // cpu divider field codes
  localparam logic [1:0] DIV_CODE_1        = 2'h0;
  localparam logic [1:0] DIV_CODE_2        = 2'h1;
  localparam logic [1:0] DIV_CODE_4        = 2'h2;
  localparam logic [1:0] DIV_CODE_16       = 2'h3;
  localparam int         DIV_CNT_W         = 4;
  // main clock stop detection: clk_in cycles without a main clock edge
  localparam int         STOP_TIME_NS      = 1000;
  localparam int         CLK_PERIOD_NS     = 10;
  localparam int         STOP_CYCLES       = STOP_TIME_NS / CLK_PERIOD_NS;
  localparam int         STOP_CNT_W        = 8;
  // glitch-free mux states
  typedef enum logic [1:0] {
    CSC_MUX_RUN   = 2'b00,
    CSC_MUX_DRAIN = 2'b01,
    CSC_MUX_SWAP  = 2'b11
  } csc_mux_state_t;
endpackage : csc_pkg
`default_nettype wire

//--- verilog/csc_trim_store.sv
// read-only trim store with registered read port
`timescale 1ns/1ps
`default_nettype none
module csc_trim_store (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  // read port
  input  wire logic [1:0] sel_in,
  output logic      [7:0] data_out
);
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      data_out <= csc_pkg::TRIM_RST;
    else
      unique case (sel_in)
        csc_pkg::TRIM_CMD_LOW:  data_out <= csc_pkg::TRIM_LOW_DEFAULT;
        csc_pkg::TRIM_CMD_UART: data_out <= csc_pkg::TRIM_UART_DEFAULT;
        default:                data_out <= csc_pkg::TRIM_RST;
      endcase
  end
endmodule : csc_trim_store
`default_nettype wire

//--- verilog/csc_clk_div.sv
// cpu clock divider as an enable-pulse generator
`timescale 1ns/1ps
`default_nettype none
module csc_clk_div (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  // source tick and ratio
  input  wire logic       tick_in,
  input  wire logic [4:0] ratio_in,
  output logic            tick_out
);
  logic [3:0] cnt_r;

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cnt_r    <= 4'h0;
      tick_out <= 1'b0;
    end
    else if (tick_in)
    begin
      // ratio change takes effect at once; a count already at or past the new ratio wraps on the next tick
      if ({1'b0, cnt_r} >= ratio_in - 5'h01)
      begin
        cnt_r    <= 4'h0;
        tick_out <= 1'b1;
      end
      else
      begin
        cnt_r    <= cnt_r + 4'h1;
        tick_out <= 1'b0;
      end
    end
    else
      tick_out <= 1'b0;
  end
endmodule : csc_clk_div
`default_nettype wire

//--- verilog/csc_clock_source_control.sv
// clock source control: oscillator enables, source select, cpu divider
// Operation
// - main oscillator stopped through and after reset
// - main starts when stop bit cleared, pins set
// - stop bit halts main oscillator when on-chip selected
// - stop bit cannot halt external main clock
// - main feedback resistor off in stop, else selectable
// - stop mode halts every clock
// - on-chip clock from high or low oscillator
// - reset cpu clock is low oscillator divided 8
// - detect 11b and main stop starts low oscillator
// - high oscillator stopped at reset, enable starts it
// - three read-only trims, first equals reset trim
// - stored 36.864 MHz trim copied before use
// - sub oscillator stopped through and after reset
// - sub starts when switch and oscillate bits set
// - sub feedback resistor follows its select bit; block forces it off in stop mode
// - divide by 8, else field picks 1/2/4/16
// - detected main stop forces source select to one
`timescale 1ns/1ps
`default_nettype none
module csc_clock_source_control (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  // control bits from software
  input  wire logic       main_osc_stop_in,
  input  wire logic       main_sub_switch_in,
  input  wire logic       main_pin_function_in,
  input  wire logic       sub_osc_enable_in,
  input  wire logic       main_feedback_res_sel_in,
  input  wire logic       sub_feedback_res_sel_in,
  input  wire logic       div8_select_in,
  input  wire logic       cpu_div_field_lo_in,
  input  wire logic       cpu_div_field_hi_in,
  input  wire logic       cpu_source_select_in,
  input  wire logic       cpu_source_select_wr_in,
  input  wire logic       stop_detect_cfg_hi_in,
  input  wire logic       stop_detect_cfg_lo_in,
  input  wire logic       hs_osc_enable_in,
  input  wire logic       onchip_osc_select_in,
  input  wire logic [2:0] hs_divide_control_in,
  input  wire logic       stop_mode_in,
  input  wire logic       external_clock_mode_in,
  // trim load
  input  wire logic [1:0] trim_copy_cmd_in,
  input  wire logic       trim_write_in,
  input  wire logic [7:0] trim_write_data_in,
  // oscillator ticks, synchronous sampled levels
  input  wire logic       main_osc_in,
  input  wire logic       sub_osc_in,
  input  wire logic       hs_osc_tick_in,
  input  wire logic       ls_osc_tick_in,
  // oscillator controls
  output logic            main_osc_run_out,
  output logic            main_osc_out,
  output logic            main_feedback_on_out,
  output logic            sub_osc_run_out,
  output logic            sub_osc_out,
  output logic            sub_feedback_on_out,
  output logic            hs_osc_run_out,
  output logic            ls_osc_run_out,
  // status and clock
  output logic            cpu_source_select_out,
  output logic            main_stop_detected_out,
  output logic [2:0]      hs_div_ratio_out,
  output logic [7:0]      hs_trim_active_out,
  output logic [7:0]      trim_store_mid_range_out,
  output logic [7:0]      trim_store_low_range_out,
  output logic [7:0]      trim_store_uart_freq_out,
  output logic            cpu_clk_tick_out
);
  logic                    src_sel_r;
  logic                    main_run_nxt;
  logic                    sub_run_nxt;
  logic                    auto_detect;
  logic [7:0]              stop_cnt_r;
  logic                    main_prev_r;
  logic                    stopped_r;
  logic                    main_edge;
  logic                    sub_prev_r;
  logic                    sub_edge;
  logic                    onchip_tick;
  logic                    main_tick;
  logic                    cur_tick;
  logic                    new_tick;
  logic                    mux_tick_r;
  logic [4:0]              ratio;
  logic [7:0]              trim_rd;
  logic                    div_tick;
  logic                    want_src_r;
  logic                    cur_src_r;
  csc_pkg::csc_mux_state_t mux_state_r;

  assign auto_detect = {stop_detect_cfg_hi_in, stop_detect_cfg_lo_in} == csc_pkg::DETECT_AUTO;

  // main runs only with pins as oscillator and stop bit cleared; external clock ignores the stop bit
  always_comb
  begin
    main_run_nxt = main_pin_function_in & ~main_sub_switch_in & ~main_osc_stop_in & ~stop_mode_in;
    if (external_clock_mode_in & main_pin_function_in & ~stop_mode_in)
      main_run_nxt = 1'b1;
    sub_run_nxt = main_sub_switch_in & sub_osc_enable_in & ~stop_mode_in;
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      main_osc_run_out     <= 1'b0;
      sub_osc_run_out      <= 1'b0;
      main_feedback_on_out <= 1'b0;
      sub_feedback_on_out  <= 1'b0;
      main_osc_out         <= 1'b0;
      sub_osc_out          <= 1'b0;
    end
    else
    begin
      main_osc_run_out     <= main_run_nxt;
      sub_osc_run_out      <= sub_run_nxt;
      // resistors follow their select bits even while the amplifier idles; stop mode turns both off
      main_feedback_on_out <= ~stop_mode_in & ~main_feedback_res_sel_in;
      sub_feedback_on_out  <= ~stop_mode_in & ~sub_feedback_res_sel_in;
      // inverting amplifier output; in stop mode held at the pin function and sub enable bits
      main_osc_out         <= stop_mode_in ? main_pin_function_in : (main_run_nxt & ~main_osc_in);
      sub_osc_out          <= stop_mode_in ? sub_osc_enable_in : (sub_run_nxt & ~sub_osc_in);
    end
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      hs_osc_run_out <= csc_pkg::HS_EN_RST;
      ls_osc_run_out <= 1'b1;
    end
    else
    begin
      hs_osc_run_out <= hs_osc_enable_in & ~stop_mode_in;
      ls_osc_run_out <= ~stop_mode_in & (src_sel_r | (auto_detect & stopped_r));
    end
  end

  // main stop detector: no main edge for a fixed window
  assign main_edge = main_osc_in ^ main_prev_r;
  // sub waveform is a level; only its rising edge may count as a source tick
  assign sub_edge  = sub_osc_in & ~sub_prev_r;

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      sub_prev_r <= 1'b0;
    else
      sub_prev_r <= sub_osc_in;
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      main_prev_r <= 1'b0;
      stop_cnt_r  <= 8'h00;
      stopped_r   <= 1'b0;
    end
    else
    begin
      main_prev_r <= main_osc_in;
      if (~auto_detect | ~main_osc_run_out | main_edge)
      begin
        stop_cnt_r <= 8'h00;
        stopped_r  <= 1'b0;
      end
      else if (stop_cnt_r == 8'(csc_pkg::STOP_CYCLES - 1))
        stopped_r  <= 1'b1;
      else
        stop_cnt_r <= stop_cnt_r + 8'h01;
    end
  end

  // detection forces on-chip; it wins over a software write of zero
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      src_sel_r <= csc_pkg::SRC_SEL_RST;
    else if (auto_detect & stopped_r)
      src_sel_r <= 1'b1;
    else if (cpu_source_select_wr_in)
      src_sel_r <= cpu_source_select_in;
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cpu_source_select_out  <= csc_pkg::SRC_SEL_RST;
      main_stop_detected_out <= 1'b0;
      hs_div_ratio_out       <= csc_pkg::HS_DIV_RST;
    end
    else
    begin
      cpu_source_select_out  <= src_sel_r;
      main_stop_detected_out <= stopped_r;
      // range limits per supply are software's duty
      hs_div_ratio_out       <= hs_divide_control_in;
    end
  end

  // trims: store read registered, copy lands one cycle later
  csc_trim_store csc_trim_store_i (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .sel_in   (trim_copy_cmd_in),
    .data_out (trim_rd)
  );

  logic [1:0] trim_cmd_r;

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      trim_cmd_r               <= csc_pkg::TRIM_CMD_NONE;
      hs_trim_active_out       <= csc_pkg::TRIM_RST;
      trim_store_mid_range_out <= csc_pkg::TRIM_RST;
      trim_store_low_range_out <= csc_pkg::TRIM_LOW_DEFAULT;
      trim_store_uart_freq_out <= csc_pkg::TRIM_UART_DEFAULT;
    end
    else
    begin
      trim_cmd_r <= trim_copy_cmd_in;
      if (trim_write_in)
        hs_trim_active_out <= trim_write_data_in;
      else if (trim_cmd_r != csc_pkg::TRIM_CMD_NONE)
        hs_trim_active_out <= trim_rd;
    end
  end

  // source ticks
  assign onchip_tick = onchip_osc_select_in ? (hs_osc_tick_in & hs_osc_run_out) : ls_osc_tick_in;
  assign main_tick   = main_sub_switch_in ? (sub_edge & sub_osc_run_out) : (main_edge & main_osc_in);
  assign cur_tick    = cur_src_r ? onchip_tick : main_tick;
  assign new_tick    = want_src_r ? onchip_tick : main_tick;

  // glitch-free swap: finish old pulse, wait a new-source edge, then change
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      mux_state_r <= csc_pkg::CSC_MUX_RUN;
      want_src_r  <= csc_pkg::SRC_SEL_RST;
      cur_src_r   <= csc_pkg::SRC_SEL_RST;
      mux_tick_r  <= 1'b0;
    end
    else
    begin
      mux_tick_r <= 1'b0;
      unique case (mux_state_r)
        csc_pkg::CSC_MUX_RUN:
        begin
          mux_tick_r <= cur_tick & ~stop_mode_in;
          if (src_sel_r != cur_src_r)
          begin
            want_src_r  <= src_sel_r;
            mux_state_r <= csc_pkg::CSC_MUX_DRAIN;
          end
        end
        csc_pkg::CSC_MUX_DRAIN:
          if (new_tick)
            mux_state_r <= csc_pkg::CSC_MUX_SWAP;
        csc_pkg::CSC_MUX_SWAP:
        begin
          cur_src_r   <= want_src_r;
          mux_state_r <= csc_pkg::CSC_MUX_RUN;
        end
        default:
          mux_state_r <= csc_pkg::CSC_MUX_RUN;
      endcase
    end
  end

  // divide ratio
  always_comb
  begin
    ratio = 5'h08;
    if (!div8_select_in)
      unique case ({cpu_div_field_hi_in, cpu_div_field_lo_in})
        csc_pkg::DIV_CODE_1:  ratio = 5'h01;
        csc_pkg::DIV_CODE_2:  ratio = 5'h02;
        csc_pkg::DIV_CODE_4:  ratio = 5'h04;
        csc_pkg::DIV_CODE_16: ratio = 5'h10;
      endcase
  end

  csc_clk_div csc_clk_div_i (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .tick_in  (mux_tick_r),
    .ratio_in (ratio),
    .tick_out (div_tick)
  );

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      cpu_clk_tick_out <= 1'b0;
    else
      cpu_clk_tick_out <= div_tick & ~stop_mode_in;
  end
endmodule : csc_clock_source_control
`default_nettype wire

//--- tb/csc_osc_model.sv
// behavioural crystal, external clock and on-chip oscillators
`timescale 1ns/1ps
`default_nettype none
module csc_osc_model (
  // run requests and faults
  input  wire logic clk_in,
  input  wire logic main_run_in,
  input  wire logic sub_run_in,
  input  wire logic hs_run_in,
  input  wire logic ls_run_in,
  input  wire logic ext_clk_in,
  input  wire logic main_dead_in,
  // waveforms and ticks
  output logic      main_osc_out,
  output logic      sub_osc_out,
  output logic      hs_tick_out,
  output logic      ls_tick_out
);
  int unsigned n = 0;
  initial {main_osc_out, sub_osc_out, hs_tick_out, ls_tick_out} = 4'h0;
  always @(posedge clk_in)
  begin
    n <= n + 1;
    // a stopped crystal freezes; an external clock ignores the stop bit
    if ((main_run_in || ext_clk_in) && !main_dead_in && n % 4 == 0) main_osc_out <= !main_osc_out;
    if (sub_run_in && n % 6 == 0) sub_osc_out <= !sub_osc_out;
    hs_tick_out <= hs_run_in && n % 3 == 0;
    ls_tick_out <= ls_run_in && n % 5 == 0;
  end
endmodule : csc_osc_model
`default_nettype wire

//--- tb/csc_clock_source_control_asserts.sv
// port assertions for the clock source control block
`timescale 1ns/1ps
`default_nettype none
module csc_clock_source_control_asserts (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic main_osc_stop_in,
  input wire logic main_sub_switch_in,
  input wire logic main_pin_function_in,
  input wire logic sub_osc_enable_in,
  input wire logic main_feedback_res_sel_in,
  input wire logic stop_detect_cfg_hi_in,
  input wire logic stop_detect_cfg_lo_in,
  input wire logic hs_osc_enable_in,
  input wire logic stop_mode_in,
  input wire logic external_clock_mode_in,
  input wire logic main_osc_run_out,
  input wire logic main_feedback_on_out,
  input wire logic sub_osc_run_out,
  input wire logic hs_osc_run_out,
  input wire logic ls_osc_run_out,
  input wire logic cpu_source_select_out,
  input wire logic main_stop_detected_out,
  input wire logic cpu_clk_tick_out
);
  logic live_r;
  // past values from the reset period are not causes
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      live_r <= 1'b0;
    else
      live_r <= 1'b1;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in || !live_r);
  sequence det_s;
    main_stop_detected_out && stop_detect_cfg_hi_in && stop_detect_cfg_lo_in;
  endsequence
  sequence fallback_s;
    cpu_source_select_out && ls_osc_run_out;
  endsequence
  AST_MAIN_OFF: assert property (
    $past(main_osc_stop_in && !main_sub_switch_in && !external_clock_mode_in && cpu_source_select_out)
    |-> !main_osc_run_out) else $error("main ran with stop set");
  AST_MAIN_ON: assert property (
    $past(!main_osc_stop_in && main_pin_function_in && !main_sub_switch_in && !stop_mode_in)
    |-> main_osc_run_out) else $error("main did not start");
  AST_STOP_ALL: assert property ($past(stop_mode_in)
    |-> !(main_osc_run_out || sub_osc_run_out || hs_osc_run_out || main_feedback_on_out))
    else $error("clock alive in stop mode");
  AST_MAIN_FB: assert property (!$past(stop_mode_in)
    |-> main_feedback_on_out == !$past(main_feedback_res_sel_in)) else $error("main feedback wrong");
  AST_SUB_ON: assert property ($past(main_sub_switch_in && sub_osc_enable_in && !stop_mode_in)
    |-> sub_osc_run_out) else $error("sub did not start");
  AST_HS_RUN: assert property (!$past(stop_mode_in)
    |-> hs_osc_run_out == $past(hs_osc_enable_in)) else $error("hs run wrong");
  AST_FALLBACK: assert property (det_s |-> ##[0:2] fallback_s)
    else $error("no fallback to low oscillator");
  AST_NO_GLITCH: assert property (cpu_clk_tick_out |=> !cpu_clk_tick_out)
    else $error("shortened cpu clock");
endmodule : csc_clock_source_control_asserts
bind csc_clock_source_control csc_clock_source_control_asserts csc_clock_source_control_asserts_i (.*);
`default_nettype wire

//--- tb/test_clock_source_control.sv
// self-checking bench for the clock source control block
`timescale 1ns/1ps
`default_nettype none
module test_clock_source_control;
  logic       clk_in, reset_in, main_osc_stop_in, main_sub_switch_in, main_pin_function_in, sub_osc_enable_in;
  logic       main_feedback_res_sel_in, sub_feedback_res_sel_in, div8_select_in, cpu_div_field_lo_in;
  logic       cpu_div_field_hi_in, cpu_source_select_in, cpu_source_select_wr_in, stop_detect_cfg_hi_in;
  logic       stop_detect_cfg_lo_in, hs_osc_enable_in, onchip_osc_select_in, stop_mode_in, external_clock_mode_in;
  logic       trim_write_in, main_dead, main_osc_in, sub_osc_in, hs_osc_tick_in, ls_osc_tick_in;
  logic       main_osc_run_out, main_osc_out, main_feedback_on_out, sub_osc_run_out, sub_osc_out;
  logic       sub_feedback_on_out, hs_osc_run_out, ls_osc_run_out, cpu_source_select_out;
  logic       main_stop_detected_out, cpu_clk_tick_out;
  logic [1:0] trim_copy_cmd_in;
  logic [2:0] hs_divide_control_in, hs_div_ratio_out;
  logic [7:0] trim_write_data_in, hs_trim_active_out, trim_store_mid_range_out;
  logic [7:0] trim_store_low_range_out, trim_store_uart_freq_out, g;
  int         num_errors = 0;
  int         cmp_count = 0;

  csc_clock_source_control csc_clock_source_control_i (.*);
  csc_osc_model csc_osc_model_i (.clk_in, .main_run_in(main_osc_run_out), .sub_run_in(sub_osc_run_out),
    .hs_run_in(hs_osc_run_out), .ls_run_in(ls_osc_run_out), .ext_clk_in(external_clock_mode_in),
    .main_dead_in(main_dead), .main_osc_out(main_osc_in), .sub_osc_out(sub_osc_in),
    .hs_tick_out(hs_osc_tick_in), .ls_tick_out(ls_osc_tick_in));

  task automatic cy(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cy

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // cpu tick spacing; early intervals are skipped while a change settles
  task automatic gap;
    int k;
    repeat (4)
    begin
      k = 0;
      do
      begin
        cy(1);
        k++;
      end
      while (cpu_clk_tick_out !== 1'b1 && k < 250);
    end
    g = k[7:0];
  endtask : gap

  task automatic wr_src(input logic v);
    cpu_source_select_in = v;
    cpu_source_select_wr_in = 1'b1;
    cy(1);
    cpu_source_select_wr_in = 1'b0;
    cy(3);
  endtask : wr_src

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic t_reset;
    chk("run", 8'({main_osc_run_out, sub_osc_run_out, hs_osc_run_out}), 8'h00);
    chk("ls", 8'({ls_osc_run_out, cpu_source_select_out}), 8'h03);
    chk("act", hs_trim_active_out, csc_pkg::TRIM_RST);
    chk("mid", trim_store_mid_range_out, csc_pkg::TRIM_RST);
    chk("low", trim_store_low_range_out, csc_pkg::TRIM_LOW_DEFAULT);
    chk("uart", trim_store_uart_freq_out, csc_pkg::TRIM_UART_DEFAULT);
    gap;
    chk("gap", g, 8'h28);
    $display("test reset done");
  endtask : t_reset

  task automatic t_trim;
    logic [1:0] cm [3] = '{csc_pkg::TRIM_CMD_LOW, csc_pkg::TRIM_CMD_UART, csc_pkg::TRIM_CMD_MID};
    logic [7:0] ex [3] = '{csc_pkg::TRIM_LOW_DEFAULT, csc_pkg::TRIM_UART_DEFAULT, csc_pkg::TRIM_RST};
    for (int i = 0; i < 3; i++)
    begin
      trim_copy_cmd_in = cm[i];
      cy(3);
      chk("trim", hs_trim_active_out, ex[i]);
    end
    trim_copy_cmd_in = csc_pkg::TRIM_CMD_NONE;
    trim_write_in = 1'b1;
    trim_write_data_in = 8'h5A;
    cy(1);
    trim_write_in = 1'b0;
    cy(2);
    chk("trimwr", hs_trim_active_out, 8'h5A);
    $display("test trim done");
  endtask : t_trim

  task automatic t_div;
    int dv [5] = '{1, 2, 4, 16, 8};
    for (int i = 0; i < 5; i++)
    begin
      {cpu_div_field_hi_in, cpu_div_field_lo_in} = 2'(i);
      div8_select_in = (i == 4);
      gap;
      chk("div", g, 8'(5 * dv[i]));
    end
    hs_osc_enable_in = 1'b1;
    onchip_osc_select_in = 1'b1;
    hs_divide_control_in = 3'h6;
    {div8_select_in, cpu_div_field_hi_in, cpu_div_field_lo_in} = 3'h0;
    gap;
    chk("hs", g, 8'h03);
    chk("ratio", 8'(hs_div_ratio_out), 8'h06);
    onchip_osc_select_in = 1'b0;
    $display("test divider done");
  endtask : t_div

  task automatic t_osc;
    main_pin_function_in = 1'b1;
    main_osc_stop_in = 1'b0;
    main_feedback_res_sel_in = 1'b1;
    cy(2);
    chk("main", 8'({main_osc_run_out, main_feedback_on_out}), 8'h02);
    main_sub_switch_in = 1'b1;
    sub_osc_enable_in = 1'b1;
    sub_feedback_res_sel_in = 1'b1;
    main_feedback_res_sel_in = 1'b0;
    cy(2);
    chk("sub", 8'({sub_osc_run_out, sub_feedback_on_out, main_feedback_on_out}), 8'h05);
    stop_mode_in = 1'b1;
    cy(2);
    chk("stop", 8'({main_osc_run_out, sub_osc_run_out, hs_osc_run_out, main_feedback_on_out}), 8'h00);
    chk("main_osc_out", 8'({main_osc_out, sub_osc_out}), 8'h03);
    stop_mode_in = 1'b0;
    main_sub_switch_in = 1'b0;
    main_osc_stop_in = 1'b1;
    cy(2);
    chk("mstop", 8'(main_osc_run_out), 8'h00);
    main_osc_stop_in = 1'b0;
    cy(20);
    $display("test oscillators done");
  endtask : t_osc

  task automatic t_fall;
    {stop_detect_cfg_hi_in, stop_detect_cfg_lo_in} = csc_pkg::DETECT_AUTO;
    wr_src(1'b0);
    chk("src", 8'({cpu_source_select_out, ls_osc_run_out}), 8'h00);
    main_dead = 1'b1;
    cy(130);
    chk("fall", 8'({main_stop_detected_out, cpu_source_select_out, ls_osc_run_out}), 8'h07);
    wr_src(1'b0);
    chk("refuse", 8'(cpu_source_select_out), 8'h01);
    main_dead = 1'b0;
    {stop_detect_cfg_hi_in, stop_detect_cfg_lo_in} = 2'h0;
    cy(3);
    wr_src(1'b0);
    external_clock_mode_in = 1'b1;
    main_osc_stop_in = 1'b1;
    {stop_detect_cfg_hi_in, stop_detect_cfg_lo_in} = csc_pkg::DETECT_AUTO;
    cy(150);
    chk("ext", 8'({main_stop_detected_out, cpu_source_select_out}), 8'h00);
    $display("test fallback done");
  endtask : t_fall

  // sub oscillator as cpu source: one cpu tick per sub rising edge at ratio 1
  task automatic t_sub;
    {stop_detect_cfg_hi_in, stop_detect_cfg_lo_in} = 2'h0;
    external_clock_mode_in = 1'b0;
    main_sub_switch_in = 1'b1;
    sub_osc_enable_in = 1'b1;
    wr_src(1'b0);
    gap;
    chk("subsrc", 8'({cpu_source_select_out, sub_osc_run_out}), 8'h01);
    chk("subgap", g, 8'h0C);
    $display("test sub source done");
  endtask : t_sub

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  initial
  begin
    #300000;
    num_errors++;
    wrap_up;
  end

  initial
  begin
    {main_sub_switch_in, main_pin_function_in, sub_osc_enable_in, main_feedback_res_sel_in} = 4'h0;
    {sub_feedback_res_sel_in, cpu_div_field_lo_in, cpu_div_field_hi_in, cpu_source_select_wr_in} = 4'h0;
    {stop_detect_cfg_hi_in, stop_detect_cfg_lo_in, hs_osc_enable_in, onchip_osc_select_in} = 4'h0;
    {stop_mode_in, external_clock_mode_in, trim_write_in, main_dead} = 4'h0;
    {main_osc_stop_in, div8_select_in, cpu_source_select_in, reset_in} = 4'hF;
    trim_copy_cmd_in = 2'h0;
    hs_divide_control_in = 3'h0;
    trim_write_data_in = 8'h00;
    repeat (3) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    t_reset;
    t_trim;
    t_div;
    t_osc;
    t_fall;
    t_sub;
    wrap_up;
  end
endmodule : test_clock_source_control
`default_nettype wire
